// ==== design/vrci_sync.v ====
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module vrci_sync #(
    parameter WIDTH = 1,
    // level both stages take in reset; set it to the pin's idle level
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // data
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // vrci_sync

// ==== design/vrci_top.v ====
// row boundary clock, interrupt and serial output enable of the voice device
`timescale 1ns/1ps
`include "vrci_defines.vh"
module vrci_top (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // serial link pins
    input  wire       ss_n_i,
    input  wire       sclk_i,
    input  wire       spi_data_i,
    output reg        miso_oe_o,
    // operation control from the command decoder
    input  wire       record_i,
    input  wire       play_i,
    input  wire       cue_mode_i,
    input  wire       last_location_i,
    input  wire       read_interrupt_instruction_i,
    input  wire [7:0] marker_mask_i,
    input  wire       sample_tick_i,
    // open-drain pins
    output reg        row_boundary_clock_o,
    output reg        row_boundary_clock_oe_o,
    output reg        irq_o,
    output reg        irq_oe_o,
    // status
    output reg        memory_end_flag_o,
    output reg        message_end_flag_o,
    output reg  [1:0] irq_status_o,
    output reg        irq_status_valid_o,
    output reg        operation_end_o
);

    // ****************************************
    // constants
    // ****************************************
    localparam [31:0] CUE_HIGH_CYC = `VRCI_CUE_HIGH_CYC;
    localparam [31:0] CUE_LOW_CYC  = `VRCI_CUE_LOW_CYC;
    localparam [10:0] ROW_TICKS    = `VRCI_TICKS_PER_ROW;
    localparam [10:0] LOW_TICKS    = ROW_TICKS / 11'd8;
    localparam [10:0] HIGH_TICKS   = ROW_TICKS - LOW_TICKS;
    localparam [7:0]  SLOT_LAST    = `VRCI_SLOT_TICKS - 1;

    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_LOAD  = 2'b01;
    localparam [1:0] ST_HIGH  = 2'b10;
    localparam [1:0] ST_LOW   = 2'b11;

    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [1:0] pins_sync;
    reg        ss_n_q;

    // select idles high, so reset must not look like a fresh select
    vrci_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({ss_n_i, sclk_i}),
        .sync_o  (pins_sync)
    );

    wire ss_n_s   = pins_sync[1];
    // serial clock edges belong to the shifter; only select matters here
    wire spi_start = ss_n_q & ~ss_n_s;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ss_n_q <= 1'b1;
        end else begin
            ss_n_q <= ss_n_s;
        end
    end

    // ****************************************
    // serial output enable
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            miso_oe_o <= 1'b0;
        end else begin
            miso_oe_o <= ~ss_n_s;
        end
    end

    // ****************************************
    // row clock sequencer
    // ****************************************
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [10:0] tick_cnt;
    reg  [10:0] next_tick_cnt;
    reg  [31:0] cue_cnt;
    reg  [31:0] next_cue_cnt;
    reg         active_q;
    wire        active   = record_i | play_i;
    wire        rec_start = record_i & ~active_q;

    // cue mode runs on fast fixed cycles since the array is skimmed, not sampled
    always @* begin
        next_state    = state;
        next_tick_cnt = tick_cnt;
        next_cue_cnt  = cue_cnt;
        case (state)
            ST_IDLE: begin
                next_tick_cnt = 11'd0;
                next_cue_cnt  = 32'd0;
                if (rec_start) begin
                    next_state = ST_LOAD;
                end else if (active) begin
                    next_state = ST_HIGH;
                end
            end
            ST_LOAD: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (sample_tick_i) begin
                    if (tick_cnt == LOW_TICKS - 11'd1) begin
                        next_tick_cnt = 11'd0;
                        next_state    = ST_HIGH;
                    end else begin
                        next_tick_cnt = tick_cnt + 11'd1;
                    end
                end
            end
            ST_HIGH: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (cue_mode_i) begin
                    if (cue_cnt >= CUE_HIGH_CYC - 32'd1) begin
                        next_cue_cnt = 32'd0;
                        next_state   = ST_LOW;
                    end else begin
                        next_cue_cnt = cue_cnt + 32'd1;
                    end
                end else if (sample_tick_i) begin
                    if (tick_cnt >= HIGH_TICKS - 11'd1) begin
                        next_tick_cnt = 11'd0;
                        next_state    = ST_LOW;
                    end else begin
                        next_tick_cnt = tick_cnt + 11'd1;
                    end
                end
            end
            ST_LOW: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (cue_mode_i) begin
                    if (cue_cnt >= CUE_LOW_CYC - 32'd1) begin
                        next_cue_cnt = 32'd0;
                        next_state   = ST_HIGH;
                    end else begin
                        next_cue_cnt = cue_cnt + 32'd1;
                    end
                end else if (sample_tick_i) begin
                    if (tick_cnt >= LOW_TICKS - 11'd1) begin
                        next_tick_cnt = 11'd0;
                        next_state    = ST_HIGH;
                    end else begin
                        next_tick_cnt = tick_cnt + 11'd1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state    <= ST_IDLE;
            tick_cnt <= 11'd0;
            cue_cnt  <= 32'd0;
            active_q <= 1'b0;
        end else begin
            state    <= next_state;
            tick_cnt <= next_tick_cnt;
            cue_cnt  <= next_cue_cnt;
            active_q <= active;
        end
    end

    // open drain: output level tied low, only the enable moves
    always @(posedge clk_i) begin
        if (rst_i) begin
            row_boundary_clock_o    <= 1'b0;
            row_boundary_clock_oe_o <= 1'b0;
        end else begin
            row_boundary_clock_o    <= 1'b0;
            row_boundary_clock_oe_o <= (next_state == ST_LOW);
        end
    end

    // ****************************************
    // end-of-message marker slots
    // ****************************************
    reg  [7:0] slot_tick;
    reg  [2:0] slot_num;
    wire       row_run   = ((state == ST_HIGH) | (state == ST_LOW)) & ~cue_mode_i;
    wire       slot_done = row_run & sample_tick_i & (slot_tick == SLOT_LAST);
    wire [7:0] slot_sel  = 8'h01 << slot_num;
    wire [7:0] slot_hit;
    genvar     g;

    // slots tile the whole row, low phase included, so the eighth ends at the row end
    always @(posedge clk_i) begin
        if (rst_i || !row_run) begin
            slot_tick <= 8'h00;
            slot_num  <= 3'h0;
        end else if (sample_tick_i) begin
            if (slot_tick == SLOT_LAST) begin
                slot_tick <= 8'h00;
                slot_num  <= slot_num + 3'h1;
            end else begin
                slot_tick <= slot_tick + 8'h01;
            end
        end
    end

    generate
        for (g = 0; g < `VRCI_MARKER_SLOTS; g = g + 1) begin : g_slot
            // a marker counts once its share of the row has been played
            assign slot_hit[g] = marker_mask_i[g] & slot_sel[g] & slot_done;
        end
    endgenerate

    wire marker_seen = play_i & ~record_i & (|slot_hit);
    wire mem_end_ev  = active & last_location_i;

    // ****************************************
    // flags and interrupt
    // ****************************************
    // set wins over the clear in the same cycle so no ending is lost
    always @(posedge clk_i) begin
        if (rst_i) begin
            memory_end_flag_o  <= 1'b0;
            message_end_flag_o <= 1'b0;
            irq_o              <= 1'b0;
            irq_oe_o           <= 1'b0;
            operation_end_o    <= 1'b0;
        end else begin
            operation_end_o <= mem_end_ev | marker_seen;
            if (mem_end_ev) begin
                memory_end_flag_o <= 1'b1;
            end else if (spi_start) begin
                memory_end_flag_o <= 1'b0;
            end
            if (marker_seen) begin
                message_end_flag_o <= 1'b1;
            end else if (spi_start) begin
                message_end_flag_o <= 1'b0;
            end
            irq_o <= 1'b0;
            if (mem_end_ev | marker_seen) begin
                irq_oe_o <= 1'b1;
            end else if (spi_start) begin
                irq_oe_o <= 1'b0;
            end
        end
    end

    // status snapshot for the read-interrupt instruction
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_o       <= 2'b00;
            irq_status_valid_o <= 1'b0;
        end else begin
            irq_status_valid_o <= read_interrupt_instruction_i;
            if (read_interrupt_instruction_i) begin
                irq_status_o[`VRCI_STAT_MEM_END] <= memory_end_flag_o;
                irq_status_o[`VRCI_STAT_MSG_END] <= message_end_flag_o;
            end
        end
    end

endmodule // vrci_top

// ==== shared/vrci_defines.vh ====
// timing counts and field positions for the row clock and interrupt block
`ifndef VRCI_DEFINES_VH
`define VRCI_DEFINES_VH

// ****************************************
// times at the 8 kHz reference rate
// ****************************************
`define VRCI_ROW_HIGH_US        175000
`define VRCI_ROW_LOW_US         25000
`define VRCI_CUE_HIGH_NS        109370
`define VRCI_CUE_LOW_NS         15630
`define VRCI_CLK_NS             25

// ****************************************
// cycle counts at 40 MHz
// ****************************************
`define VRCI_ROW_HIGH_CYC       ((`VRCI_ROW_HIGH_US * 1000) / `VRCI_CLK_NS)
`define VRCI_ROW_LOW_CYC        ((`VRCI_ROW_LOW_US * 1000) / `VRCI_CLK_NS)
`define VRCI_CUE_HIGH_CYC       (`VRCI_CUE_HIGH_NS / `VRCI_CLK_NS)
`define VRCI_CUE_LOW_CYC        (`VRCI_CUE_LOW_NS / `VRCI_CLK_NS)

// ****************************************
// sample-rate step: reference rate is one sample tick per 125 us
// ****************************************
`define VRCI_TICKS_PER_ROW      1600
`define VRCI_MARKER_SLOTS       8
`define VRCI_SLOT_TICKS         200

// ****************************************
// interrupt status word bits
// ****************************************
`define VRCI_STAT_MEM_END       0
`define VRCI_STAT_MSG_END       1

`endif

// ==== tb/vrci_chk.sv ====
// assertions on the pins of the row clock and interrupt block
`timescale 1ns/1ps
module vrci_chk (
    input logic       clk_i, rst_i, ss_n_i, miso_oe_o,
    input logic       record_i, play_i, last_location_i,
    input logic       read_interrupt_instruction_i,
    input logic       row_boundary_clock_o, irq_o, irq_oe_o,
    input logic       memory_end_flag_o, message_end_flag_o,
    input logic [1:0] irq_status_o,
    input logic       irq_status_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_miso_off; ss_n_i [*4] |-> !miso_oe_o; endproperty
    a_miso_off: assert property (p_miso_off) else $error("serial out driven while idle");
    property p_miso_on; $fell(ss_n_i) ##1 !ss_n_i [*4] |-> miso_oe_o; endproperty
    a_miso_on: assert property (p_miso_on) else $error("serial out not driven");
    property p_row_od; !row_boundary_clock_o; endproperty
    a_row_od: assert property (p_row_od) else $error("row clock driven high");
    property p_irq_od; !irq_o; endproperty
    a_irq_od: assert property (p_irq_od) else $error("interrupt driven high");
    // short frames are never sent, so four idle samples rule out a clear in flight
    property p_irq_hold;
        irq_oe_o && ss_n_i && $past(ss_n_i) && $past(ss_n_i, 2) && $past(ss_n_i, 3) |=> irq_oe_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
    property p_irq_clr; $fell(ss_n_i) |-> ##[1:5] !irq_oe_o; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
    property p_mem_end;
        (record_i || play_i) && last_location_i |-> ##[1:2] (memory_end_flag_o && irq_oe_o);
    endproperty
    a_mem_end: assert property (p_mem_end) else $error("memory end not flagged");
    property p_msg_play; $rose(message_end_flag_o) |-> $past(play_i) && !$past(record_i); endproperty
    a_msg_play: assert property (p_msg_play) else $error("message end outside playback");
    property p_rd_stat;
        read_interrupt_instruction_i |=> irq_status_valid_o
            && irq_status_o == {$past(message_end_flag_o), $past(memory_end_flag_o)};
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");
endmodule // vrci_chk

// ==== tb/vrci_host.sv ====
// host side of the serial link: select, clock and data
`timescale 1ns/1ps
module vrci_host (
    output logic ss_n_o,
    output logic sclk_o,
    output logic mosi_o
);
    initial begin
        ss_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // clock stands still between frames; 200 ns period inside
    task automatic frame(input logic [7:0] b);
        ss_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi_o = b[i];
            #100 sclk_o = 1'b1;
            #100 sclk_o = 1'b0;
        end
        ss_n_o = 1'b1;
        // released line shows the inverse, never a stale copy
        mosi_o = ~mosi_o;
    endtask
endmodule // vrci_host

// ==== tb/vrci_top_tb.sv ====
// self-checking bench for the row clock and interrupt block
`timescale 1ns/1ps
`include "vrci_defines.vh"
module vrci_top_tb;
    localparam int ROW_T = `VRCI_TICKS_PER_ROW;
    localparam int HI_T  = ROW_T * 175 / 200;
    localparam int LO_T  = ROW_T * 25 / 200;
    logic       clk_i = 1'b0, rst_i = 1'b1, ss_n, sclk, mosi;
    logic       record_i = 1'b0, play_i = 1'b0, cue_i = 1'b0, last_i = 1'b0, rii = 1'b0, tick = 1'b0;
    logic [7:0] mask = 8'h00;
    wire        miso_oe, row_o, row_oe, irq_o, irq_oe, mem_f, msg_f, st_v, op_end;
    wire  [1:0] st;
    int         fail_count = 0, num_checks = 0, cyc = 0, tp = 2, tcnt = 0, tk, n;
    vrci_host host_i (.ss_n_o(ss_n), .sclk_o(sclk), .mosi_o(mosi));
    vrci_top vrci_top_i (.clk_i(clk_i), .rst_i(rst_i), .ss_n_i(ss_n), .sclk_i(sclk), .spi_data_i(mosi),
        .miso_oe_o(miso_oe), .record_i(record_i), .play_i(play_i), .cue_mode_i(cue_i),
        .last_location_i(last_i), .read_interrupt_instruction_i(rii), .marker_mask_i(mask),
        .sample_tick_i(tick), .row_boundary_clock_o(row_o), .row_boundary_clock_oe_o(row_oe),
        .irq_o(irq_o), .irq_oe_o(irq_oe), .memory_end_flag_o(mem_f), .message_end_flag_o(msg_f),
        .irq_status_o(st), .irq_status_valid_o(st_v), .operation_end_o(op_end));
    initial forever #12.5 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        tcnt <= (tcnt >= tp - 1) ? 0 : tcnt + 1;
        tick <= (tcnt == 0);
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ****
    // checks and helpers
    // ****
    task automatic chk(input string nm, input int e, input int g, input int tol);
        num_checks++;
        if (g > e + tol || g < e - tol) begin
            fail_count++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic [1:0] e, input logic [1:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    // time spent by the row clock at one level, in ticks and clocks
    task automatic meas(input logic lvl, output int t, output int c);
        t = 0;
        c = 0;
        while (row_oe === lvl && c < 20000) begin
            @(negedge clk_i);
            c++;
            t += tick;
        end
    endtask
    task automatic clear_irq();
        host_i.frame(8'h30);
        repeat (6) @(negedge clk_i);
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        mask = 8'hFF;
        record_i = 1'b1;
        meas(1'b0, tk, n);
        chk("record first high", LO_T + HI_T, tk, 1);
        meas(1'b1, tk, n);
        chk("row low ticks", LO_T, tk, 1);
        tp = 3;
        meas(1'b0, tk, n);
        chk("row high ticks", HI_T, tk, 1);
        meas(1'b1, tk, n);
        chk("row low clocks", LO_T * 3, n, 3);
        tp = 2;
        last_i = 1'b1;
        @(negedge clk_i);
        chkb("op end pulse", 2'h1, op_end);
        last_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chkb("op end one cycle", 2'h0, op_end);
        chkb("mem end flag", 2'h1, mem_f);
        chkb("irq pulled", 2'h1, irq_oe);
        chkb("msg end in record", 2'h0, msg_f);
        rii = 1'b1;
        @(negedge clk_i);
        chkb("status valid", 2'h1, st_v);
        rii = 1'b0;
        repeat (2) @(negedge clk_i);
        chkb("irq status", 2'h1, st);
        record_i = 1'b0;
        clear_irq();
        chkb("irq cleared", 2'h0, irq_oe);
        for (int g = 0; g < 8; g++) begin
            mask = 8'h01 << g;
            play_i = 1'b1;
            n = 0;
            while (msg_f !== 1'b1 && n < 4 * ROW_T * tp) begin
                @(negedge clk_i);
                n++;
            end
            play_i = 1'b0;
            chkb("msg end per slot", 2'h1, msg_f);
            chkb("irq per operation", 2'h1, irq_oe);
            clear_irq();
        end
        mask = 8'h00;
        cue_i = 1'b1;
        play_i = 1'b1;
        meas(1'b0, tk, n);
        meas(1'b1, tk, n);
        chk("cue low", `VRCI_CUE_LOW_CYC, n, 1);
        meas(1'b0, tk, n);
        chk("cue high", `VRCI_CUE_HIGH_CYC, n, 1);
        report_and_stop();
    end
endmodule // vrci_top_tb
bind vrci_top vrci_chk vrci_chk_i (.clk_i, .rst_i, .ss_n_i, .miso_oe_o, .record_i, .play_i,
    .last_location_i, .read_interrupt_instruction_i, .row_boundary_clock_o, .irq_o, .irq_oe_o,
    .memory_end_flag_o, .message_end_flag_o, .irq_status_o, .irq_status_valid_o);
